/* File: inc/ldrm_pkg.sv */
package ldrm_pkg;
   // ==========================================================
   // sizes
   localparam int SEG_N = 34;
   localparam int COM_N = 4;
   localparam int DREG_N = 16;
   localparam int ENTRY_N = SEG_N * COM_N;
   localparam int PORT_N = 8;
   localparam int PORT_SEG_LO = 26;
   localparam int ADDR_W = 12;
   localparam int CNT_W = 22;
   // ==========================================================
   // timing: frame rates in millihertz, clock in hertz
   localparam longint CLK_HZ = 200_000_000;
   localparam longint FRAME_64_MHZ = 64_000;
   localparam longint FRAME_83_MHZ = 83_340;
   localparam longint FRAME_CYC_64 = (CLK_HZ * 1000) / FRAME_64_MHZ;
   localparam longint FRAME_CYC_83 = (CLK_HZ * 1000) / FRAME_83_MHZ;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STAT_ADDR = 12'h004;
   localparam logic [11:0] DISP_BASE = 12'h040;
   localparam logic [11:0] MAP_BASE = 12'h100;
   // control fields
   localparam int CTRL_DUTY_LSB = 0;
   localparam int CTRL_PORT_BIT = 2;
   localparam int CTRL_GATE_BIT = 3;
   // map entry fields: valid, register index, bit index
   localparam int MAP_VALID_BIT = 6;
   localparam int MAP_W = 7;
   localparam logic [6:0] MAP_RESET = 7'h00;
   localparam logic [3:0] DISP_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      LDRM_DUTY_OFF = 2'b00,
      LDRM_DUTY_HALF = 2'b01,
      LDRM_DUTY_THIRD = 2'b10,
      LDRM_DUTY_QUARTER = 2'b11
   } ldrm_duty_t;

   typedef enum logic [2:0] {
      LDRM_SEL_CTRL = 3'b000,
      LDRM_SEL_STAT = 3'b001,
      LDRM_SEL_DISP = 3'b010,
      LDRM_SEL_MAP = 3'b011,
      LDRM_SEL_NONE = 3'b100
   } ldrm_sel_t;

   typedef enum logic [1:0] {
      LDRM_RD_IDLE = 2'b00,
      LDRM_RD_FETCH = 2'b01,
      LDRM_RD_RESP = 2'b10
   } ldrm_rd_state_t;

   typedef struct packed {
      logic en;
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } ldrm_wr_req_t;

   typedef struct packed {
      logic aw_have;
      logic w_have;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      ldrm_wr_req_t wr;
      ldrm_rd_state_t rd_state;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [11:0] rd_addr;
   } ldrm_bus_st_t;

   typedef struct packed {
      logic [DREG_N-1:0][3:0] disp;
      ldrm_duty_t duty;
      logic port_mode;
      logic gate;
      logic [1:0] pin_sync;
      logic [CNT_W-1:0] cnt;
      logic [1:0] phase;
      logic [SEG_N-1:0] seg;
      logic [COM_N-1:0] com;
      logic [PORT_N-1:0] port;
      logic ureset;
   } ldrm_core_st_t;
endpackage : ldrm_pkg

/* File: src/ldrm_axil_slave.sv */
`timescale 1ns/1ps
module ldrm_axil_slave
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output ldrm_pkg::ldrm_wr_req_t wr,
   input wire logic wr_err,
   output logic [11:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   ldrm_pkg::ldrm_bus_st_t s_q;
   ldrm_pkg::ldrm_bus_st_t s_d;

   // ==========================================================
   // write channels: address and data taken in either order
   always_comb
   begin
      s_d = s_q;
      s_d.wr.en = 1'b0;
      if (awvalid && s_q.awready)
      begin
         s_d.aw_have = 1'b1;
         s_d.wr.addr = awaddr;
      end
      if (wvalid && s_q.wready)
      begin
         s_d.w_have = 1'b1;
         s_d.wr.data = wdata;
         s_d.wr.strb = wstrb;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
      begin
         // the core commits the write on the edge that raises bvalid + 1
         s_d.wr.en = 1'b1;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_err ? ldrm_pkg::RESP_SLVERR : ldrm_pkg::RESP_OKAY;
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
      end
      if (s_q.bvalid && bready)
      begin
         s_d.bvalid = 1'b0;
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;
      // ==========================================================
      // read channel
      case (s_q.rd_state)
         ldrm_pkg::LDRM_RD_IDLE:
         begin
            if (arvalid)
            begin
               s_d.rd_addr = araddr;
               s_d.arready = 1'b0;
               s_d.rd_state = ldrm_pkg::LDRM_RD_FETCH;
            end
         end
         ldrm_pkg::LDRM_RD_FETCH:
         begin
            s_d.rdata = rd_data;
            s_d.rresp = rd_err ? ldrm_pkg::RESP_SLVERR : ldrm_pkg::RESP_OKAY;
            s_d.rvalid = 1'b1;
            s_d.rd_state = ldrm_pkg::LDRM_RD_RESP;
         end
         ldrm_pkg::LDRM_RD_RESP:
         begin
            if (rready)
            begin
               s_d.rvalid = 1'b0;
               s_d.arready = 1'b1;
               s_d.rd_state = ldrm_pkg::LDRM_RD_IDLE;
            end
         end
         default:
         begin
            s_d.rd_state = ldrm_pkg::LDRM_RD_IDLE;
            s_d.arready = 1'b1;
            s_d.rvalid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.rd_state <= ldrm_pkg::LDRM_RD_IDLE;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rresp = s_q.rresp;
   assign rdata = s_q.rdata;
   assign wr = s_q.wr;
   assign rd_addr = s_q.rd_addr;
endmodule : ldrm_axil_slave

/* File: src/ldrm_lcd_display.sv */
`timescale 1ns/1ps
module ldrm_lcd_display
#(
   parameter int unsigned PHASE_CYC_HALF = int'(ldrm_pkg::FRAME_CYC_64 / 2),
   parameter int unsigned PHASE_CYC_THIRD = int'(ldrm_pkg::FRAME_CYC_83 / 3),
   parameter int unsigned PHASE_CYC_QUARTER = int'(ldrm_pkg::FRAME_CYC_64 / 4)
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic user_reset_pin_n,
   input wire logic emulation_run,
   output logic [ldrm_pkg::SEG_N-1:0] seg_out,
   output logic [ldrm_pkg::COM_N-1:0] com_out,
   output logic [ldrm_pkg::PORT_N-1:0] port_out,
   output logic port_mode,
   output logic user_reset
);
   ldrm_pkg::ldrm_core_st_t s_q;
   ldrm_pkg::ldrm_core_st_t s_d;
   ldrm_pkg::ldrm_wr_req_t wr;
   logic [ldrm_pkg::MAP_W-1:0] map_mem [ldrm_pkg::ENTRY_N];
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;
   logic wr_err;
   logic [ldrm_pkg::ENTRY_N-1:0] entry_wins;
   logic [ldrm_pkg::DREG_N*4-1:0] disp_flat;
   logic ureset_now;
   localparam int CNT_W_L = ldrm_pkg::CNT_W;

   // ==========================================================
   // address decode, shared by the read and write paths
   function automatic ldrm_pkg::ldrm_sel_t sel_of(input logic [11:0] a);
      ldrm_pkg::ldrm_sel_t r;
      r = ldrm_pkg::LDRM_SEL_NONE;
      if (a[1:0] != 2'b00)
      begin
         r = ldrm_pkg::LDRM_SEL_NONE;
      end
      else if (a == ldrm_pkg::CTRL_ADDR)
      begin
         r = ldrm_pkg::LDRM_SEL_CTRL;
      end
      else if (a == ldrm_pkg::STAT_ADDR)
      begin
         r = ldrm_pkg::LDRM_SEL_STAT;
      end
      else if (a >= ldrm_pkg::DISP_BASE
               && a < ldrm_pkg::DISP_BASE + 12'(ldrm_pkg::DREG_N * 4))
      begin
         r = ldrm_pkg::LDRM_SEL_DISP;
      end
      else if (a >= ldrm_pkg::MAP_BASE
               && a < ldrm_pkg::MAP_BASE + 12'(ldrm_pkg::ENTRY_N * 4))
      begin
         r = ldrm_pkg::LDRM_SEL_MAP;
      end
      return r;
   endfunction : sel_of

   function automatic logic [7:0] word_of(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return d[9:2];
   endfunction : word_of

   // ==========================================================
   // bus slave
   ldrm_axil_slave u_bus
   (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .ce(ce),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr(wr),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   assign wr_err = (sel_of(wr.addr) == ldrm_pkg::LDRM_SEL_NONE);
   assign rd_err = (sel_of(rd_addr) == ldrm_pkg::LDRM_SEL_NONE);

   // ==========================================================
   // read mux
   always_comb
   begin
      rd_data = 32'h0000_0000;
      case (sel_of(rd_addr))
         ldrm_pkg::LDRM_SEL_CTRL:
         begin
            rd_data[ldrm_pkg::CTRL_DUTY_LSB +: 2] = s_q.duty;
            rd_data[ldrm_pkg::CTRL_PORT_BIT] = s_q.port_mode;
            rd_data[ldrm_pkg::CTRL_GATE_BIT] = s_q.gate;
         end
         ldrm_pkg::LDRM_SEL_STAT:
         begin
            rd_data[1:0] = s_q.phase;
            rd_data[2] = s_q.ureset;
            rd_data[3] = s_q.pin_sync[1];
         end
         ldrm_pkg::LDRM_SEL_DISP:
         begin
            rd_data[3:0] = s_q.disp[word_of(rd_addr, ldrm_pkg::DISP_BASE)];
         end
         ldrm_pkg::LDRM_SEL_MAP:
         begin
            rd_data[ldrm_pkg::MAP_W-1:0] = map_mem[word_of(rd_addr, ldrm_pkg::MAP_BASE)];
         end
         default:
         begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // drive-assignment table; entry index is segment * 4 + common
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < ldrm_pkg::ENTRY_N; i++)
         begin
            map_mem[i] <= ldrm_pkg::MAP_RESET;
         end
      end
      else if (ce && wr.en && wr.strb[0] && sel_of(wr.addr) == ldrm_pkg::LDRM_SEL_MAP)
      begin
         map_mem[word_of(wr.addr, ldrm_pkg::MAP_BASE)] <= wr.data[ldrm_pkg::MAP_W-1:0];
      end
   end

   // ==========================================================
   // ownership: an entry wins unless a later entry (higher segment,
   // or same segment and higher common) names the same display bit.
   // costly in compares, but keeps the table free of any order rule.
   always_comb
   begin
      for (int e = 0; e < ldrm_pkg::ENTRY_N; e++)
      begin
         entry_wins[e] = map_mem[e][ldrm_pkg::MAP_VALID_BIT];
         for (int f = e + 1; f < ldrm_pkg::ENTRY_N; f++)
         begin
            if (map_mem[f][ldrm_pkg::MAP_VALID_BIT]
                && map_mem[f][5:0] == map_mem[e][5:0])
            begin
               entry_wins[e] = 1'b0;
            end
         end
      end
   end

   assign disp_flat = s_q.disp;
   assign ureset_now = s_q.gate && emulation_run && !s_q.pin_sync[1];

   // ==========================================================
   // core state
   always_comb
   begin
      logic [CNT_W_L-1:0] reload;
      logic [1:0] last_phase;
      logic [7:0] idx;
      reload = '0;
      last_phase = 2'd0;
      idx = 8'h00;
      s_d = s_q;
      s_d.pin_sync = {s_q.pin_sync[0], user_reset_pin_n};
      s_d.ureset = ureset_now;
      // register writes; only byte lane 0 carries data
      if (wr.en && wr.strb[0])
      begin
         case (sel_of(wr.addr))
            ldrm_pkg::LDRM_SEL_CTRL:
            begin
               s_d.duty = ldrm_pkg::ldrm_duty_t'(wr.data[ldrm_pkg::CTRL_DUTY_LSB +: 2]);
               s_d.port_mode = wr.data[ldrm_pkg::CTRL_PORT_BIT];
               s_d.gate = wr.data[ldrm_pkg::CTRL_GATE_BIT];
            end
            ldrm_pkg::LDRM_SEL_DISP:
            begin
               s_d.disp[word_of(wr.addr, ldrm_pkg::DISP_BASE)] = wr.data[3:0];
            end
            default:
            begin
               s_d.duty = s_q.duty;
            end
         endcase
      end
      // phase length per duty: frame time split over the active commons
      case (s_q.duty)
         ldrm_pkg::LDRM_DUTY_HALF:
         begin
            reload = CNT_W_L'(PHASE_CYC_HALF - 1);
            last_phase = 2'd1;
         end
         ldrm_pkg::LDRM_DUTY_THIRD:
         begin
            reload = CNT_W_L'(PHASE_CYC_THIRD - 1);
            last_phase = 2'd2;
         end
         ldrm_pkg::LDRM_DUTY_QUARTER:
         begin
            reload = CNT_W_L'(PHASE_CYC_QUARTER - 1);
            last_phase = 2'd3;
         end
         default:
         begin
            reload = '0;
            last_phase = 2'd0;
         end
      endcase
      if (ureset_now || s_q.duty == ldrm_pkg::LDRM_DUTY_OFF)
      begin
         // user reset restarts the scan but leaves display data alone
         s_d.cnt = '0;
         s_d.phase = 2'd0;
         s_d.com = '0;
         s_d.seg = '0;
      end
      else
      begin
         // a duty change can leave the phase past the new last common
         if (s_q.cnt >= reload || s_q.phase > last_phase)
         begin
            s_d.cnt = '0;
            s_d.phase = (s_q.phase >= last_phase) ? 2'd0 : s_q.phase + 2'd1;
         end
         else
         begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
         s_d.com = '0;
         s_d.com[s_d.phase] = 1'b1;
         for (int sg = 0; sg < ldrm_pkg::SEG_N; sg++)
         begin
            idx = 8'(sg * ldrm_pkg::COM_N) + {6'h00, s_d.phase};
            s_d.seg[sg] = entry_wins[idx] && disp_flat[map_mem[idx][5:0]];
         end
      end
      // port mode: register 0 feeds the lower four pins, register 1 the upper four
      s_d.port = {s_q.disp[1], s_q.disp[0]};
      if (s_q.port_mode)
      begin
         s_d.seg[ldrm_pkg::PORT_SEG_LO +: ldrm_pkg::PORT_N] = s_d.port;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
         s_q.disp <= {ldrm_pkg::DREG_N{ldrm_pkg::DISP_RESET}};
         s_q.pin_sync <= 2'b11;
         s_q.duty <= ldrm_pkg::LDRM_DUTY_OFF;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign seg_out = s_q.seg;
   assign com_out = s_q.com;
   assign port_out = s_q.port;
   assign port_mode = s_q.port_mode;
   assign user_reset = s_q.ureset;
endmodule : ldrm_lcd_display

/* File: tb/ldrm_lcd_display_properties.sv */
`timescale 1ns/1ps
// ======
// protocol and drive checks
module ldrm_lcd_display_chk
#(
   parameter int PH_H = 8
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic user_reset_pin_n,
   input wire logic [33:0] seg_out,
   input wire logic [3:0] com_out,
   input wire logic user_reset
);
   // half duty has the longest phase, so it bounds every phase
   logic [3:0] com_q;
   logic [31:0] run_q;
   always_ff @(posedge sys_clk)
   begin
      com_q <= com_out;
      run_q <= (!reset_n || com_out != com_q) ? 32'h1 : run_q + 32'h1;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   AST_READY_RST: assert property ($rose(reset_n) |-> s_axi_awready && s_axi_arready)
      else $error("bus not ready after reset");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer late");
   AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   AST_AR_HOLD: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("second read accepted");
   AST_COM_ONEHOT: assert property ($onehot0(com_out))
      else $error("several commons active");
   AST_UR_COM: assert property (user_reset && $past(user_reset) |-> com_out == 4'h0)
      else $error("commons run in user reset");
   AST_UR_PIN: assert property (user_reset_pin_n [*5] |-> !user_reset)
      else $error("user reset without pin");
   AST_PHASE_MAX: assert property (com_out != 4'h0 && com_out == com_q |-> run_q < PH_H)
      else $error("phase too long");
   AST_SEG_AT_PHASE: assert property ($changed(seg_out)
      |-> $changed(com_out) || $past(s_axi_bvalid, 2)) else $error("segments moved mid phase");
   cover property (user_reset);
   cover property (com_out == 4'h8);
   cover property (s_axi_bvalid);
endmodule : ldrm_lcd_display_chk

/* File: tb/ldrm_panel_model.sv */
`timescale 1ns/1ps
// ======
// panel: keeps the lit segments per common and times the phases
module ldrm_panel_model
(
   input wire logic sys_clk,
   input wire logic clr,
   input wire logic [33:0] seg_out,
   input wire logic [3:0] com_out,
   output logic [3:0][33:0] lit_q,
   output logic [3:0] seen_q,
   output logic [31:0] plen_q
);
   logic [3:0] prev_q;
   logic [31:0] run_q;
   always_ff @(posedge sys_clk)
   begin
      prev_q <= com_out;
      seen_q <= clr ? 4'h0 : seen_q | com_out;
      run_q <= (clr || com_out != prev_q) ? 32'h1 : run_q + 32'h1;
      // first length after clr may be partial; readers wait several phases
      if (com_out != prev_q)
         plen_q <= run_q;
      for (int c = 0; c < 4; c++)
         if (com_out[c])
            lit_q[c] <= seg_out;
   end
endmodule : ldrm_panel_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
// ======
// bench top
module tb;
   localparam int PH_H = 8;
   localparam int PH_T = 6;
   localparam int PH_Q = 4;
   localparam logic [1:0] OK = ldrm_pkg::RESP_OKAY;
   localparam logic [11:0] C = ldrm_pkg::CTRL_ADDR;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce_en = 1'b1;
   logic awvalid, wvalid, bready, arvalid, rready, pin_n, emu_run, pclr;
   logic awready, wready, bvalid, arready, rvalid, port_mode, user_reset;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, plen;
   logic [1:0] bresp, rresp;
   logic [33:0] seg_out;
   logic [3:0] com_out, seen;
   logic [7:0] port_out;
   logic [3:0][33:0] lit;
   int fail_count = 0;
   int tests_run = 0;
   ldrm_lcd_display #(.PHASE_CYC_HALF(PH_H), .PHASE_CYC_THIRD(PH_T), .PHASE_CYC_QUARTER(PH_Q))
   dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce_en), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .user_reset_pin_n(pin_n), .emulation_run(emu_run), .seg_out(seg_out),
      .com_out(com_out), .port_out(port_out), .port_mode(port_mode), .user_reset(user_reset));
   ldrm_panel_model panel_u (.sys_clk(sys_clk), .clr(pclr), .seg_out(seg_out),
      .com_out(com_out), .lit_q(lit), .seen_q(seen), .plen_q(plen));
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [11:0] da(input int i);
      return ldrm_pkg::DISP_BASE + 12'(4 * i);
   endfunction : da
   // one bus access; a read also compares its data
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v,
      input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      awaddr <= a;
      araddr <= a;
      wdata <= v;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      for (n = 0; n < 100; n++)
      begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         if (w ? bvalid : rvalid) break;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      chk(34'({n < 100, w ? bresp : rresp}), 34'({1'b1, er}));
      if (!w) chk(34'(rdata), 34'(v));
   endtask : acc
   task automatic t_regs;
      for (int i = 0; i < 16; i++)
         acc(1'b0, da(i), 32'h0, OK);
      acc(1'b0, 12'h800, 32'h0, ldrm_pkg::RESP_SLVERR);
      acc(1'b1, 12'h800, 32'h1, ldrm_pkg::RESP_SLVERR);
      for (int i = 0; i < 16; i++)
      begin
         acc(1'b1, da(i), 32'hf, OK);
         acc(1'b0, da(i), 32'hf, OK);
         acc(1'b1, da(i), 32'(i), OK);
         acc(1'b0, da(i), 32'(i), OK);
      end
      chk(34'(port_out), 34'h10);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_port;
      acc(1'b1, C, 32'h4, OK);
      acc(1'b1, da(0), 32'ha, OK);
      acc(1'b1, da(1), 32'h5, OK);
      repeat (3) @(posedge sys_clk);
      chk(34'(seg_out[33:26]), 34'h5a);
      chk(34'({port_mode, port_out}), 34'h15a);
      acc(1'b1, C, 32'h0, OK);
      $display("t_port done");
   endtask : t_port
   task automatic t_duty;
      logic [3:0] held;
      for (int k = 1; k < 4; k++)
      begin
         acc(1'b1, C, 32'(k), OK);
         pclr <= 1'b1;
         @(posedge sys_clk);
         pclr <= 1'b0;
         repeat (60) @(posedge sys_clk);
         chk(34'(seen), 34'((1 << (k + 1)) - 1));
         chk(34'(plen), 34'(k == 1 ? PH_H : (k == 2 ? PH_T : PH_Q)));
      end
      // clock enable low must freeze the scan; kept under one phase for the checker
      ce_en <= 1'b0;
      @(posedge sys_clk);
      held = com_out;
      repeat (2) @(posedge sys_clk);
      chk(34'(com_out), 34'(held));
      ce_en <= 1'b1;
      acc(1'b1, C, 32'h0, OK);
      repeat (3) @(posedge sys_clk);
      chk(34'(com_out), 34'h0);
      $display("t_duty done");
   endtask : t_duty
   // map entry index is segment*4+common: 28/3 and 29/3 both take bit 3 of register 2
   task automatic t_prio;
      acc(1'b1, da(2), 32'h8, OK);
      acc(1'b1, 12'h2cc, 32'h4b, OK);
      acc(1'b1, 12'h2dc, 32'h4b, OK);
      acc(1'b0, 12'h2cc, 32'h4b, OK);
      acc(1'b1, C, 32'h3, OK);
      repeat (40) @(posedge sys_clk);
      chk(34'(lit[3][29]), 34'h1);
      chk(34'(lit[3][28]), 34'h0);
      $display("t_prio done");
   endtask : t_prio
   task automatic pin_pulse(input logic [11:0] ctl, input logic run, input logic exp);
      acc(1'b1, C, 32'(ctl), OK);
      emu_run <= run;
      pin_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(34'({user_reset, exp ? com_out : 4'h0}), 34'({exp, 4'h0}));
      pin_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk(34'(user_reset), 34'h0);
   endtask : pin_pulse
   task automatic t_user_rst;
      pin_pulse(12'hb, 1'b1, 1'b1);
      acc(1'b0, da(2), 32'h8, OK);
      acc(1'b0, 12'h2cc, 32'h4b, OK);
      acc(1'b0, C, 32'hb, OK);
      pin_pulse(12'h3, 1'b1, 1'b0);
      pin_pulse(12'hb, 1'b0, 1'b0);
      $display("t_user_rst done");
   endtask : t_user_rst
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_of_test();
   end
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, pclr, emu_run} = 7'h0;
      pin_n = 1'b1;
      {awaddr, araddr, wdata} = 56'h0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_port();
      t_duty();
      t_prio();
      t_user_rst();
      reset_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      acc(1'b0, da(2), 32'h0, OK);
      acc(1'b0, C, 32'h0, OK);
      acc(1'b0, ldrm_pkg::STAT_ADDR, 32'h8, OK);
      end_of_test();
   end
endmodule : tb
bind ldrm_lcd_display ldrm_lcd_display_chk #(.PH_H(int'(PHASE_CYC_HALF))) chk_u (
   .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .user_reset_pin_n(user_reset_pin_n), .seg_out(seg_out),
   .com_out(com_out), .user_reset(user_reset));
